/* design/pin_mux_params.svh */
// Purpose: constants for the transceiver pin function mux
// Assumes: 100 MHz system clock
// Notes: times in ns, counts derived from them
`ifndef PIN_MUX_PARAMS_SVH
`define PIN_MUX_PARAMS_SVH

`define CLK_PERIOD_NS 10
// ----------
// timing
// ----------
`define SYNC_LOSS_TIME_NS 100000
`define SYNC_LOSS_CYCLES ((`SYNC_LOSS_TIME_NS) / (`CLK_PERIOD_NS))
`define STRAP_SETTLE_CYCLES 4
`define AUX_CLK_HALF 4
`define MIC_CLK_HALF 8
`define BIT_CLK_HALF 2
// ----------
// stream shape
// ----------
`define FRAME_BITS 32
`define WORD_W 32
`define TX_FIFO_DEPTH 16
// ----------
// pin indices in the enable vectors
// ----------
`define PIN_STRAP_B 0
`define PIN_BCLK 1
`define PIN_FSYNC 2
`define PIN_TX0 3
`define PIN_TX1 4
`define PIN_RX0 5
`define PIN_COUNT 6
// ----------
// gpio indices
// ----------
`define GPIO_STRAP_B 0
`define GPIO_THREE 1
`define GPIO_FOUR 2
`define GPIO_FIVE 3
`define GPIO_COUNT 4

`endif

/* design/pin_mux_pkg.sv */
// Purpose: types for the transceiver pin function mux
// Assumes: nothing
// Notes: gray coded along the usual path
package pin_mux_pkg;
	typedef enum logic [2:0] {
		fn_hiz = 3'h0,
		fn_gpio = 3'h1,
		fn_clk = 3'h3,
		fn_mic = 3'h2,
		fn_serial = 3'h6
	} pin_fn_t;

	typedef enum logic [1:0] {
		hs_idle = 2'h0,
		hs_busy = 2'h1
	} hs_state_t;
endpackage

/* design/transceiver_pin_function_mux.sv */
// Purpose: pin function selection, direction and serial lanes of the digital I/O
// Assumes: config ports come from logic on clk; link_clk is the bit clock
// Notes: output enables active low; all pins high impedance in reset
//
// Behaviour
// - capture both address straps after reset release into target address.
// - strap b pin stays high impedance until gpio or auxiliary clock configured.
// - strap b pin may output the auxiliary clock b.
// - bit clock pin is input in main role, driven in subordinate role.
// - subordinate with microphone may put mic clock on bit clock pin.
// - frame sync pin is input in main role, driven in subordinate.
// - frame sync marks word boundary of the serial lanes.
// - in main role, frame sync stopping for a timeout resets the audio bus.
// - full variant drives serial transmit data on lane zero pin.
// - lane zero pin is gpio three when transmit off, hiz until configured.
// - sync loss returns every configurable pin to high impedance.
// - reduced variant offers only gpio on both transmit pins.
// - lane one pin transmits or, with mic busy, receives serial data.
// - lane one pin is gpio four otherwise, hiz until configured.
// - receive pin takes serial, else mic input, else gpio five.
// - reduced variant has no serial receive on receive pin.
// - in reset every pin is three-stated with inputs disabled.
`timescale 1ns/100ps
`include "pin_mux_params.svh"

// ---------------------------------------------------------------
// transmit word buffer
// ---------------------------------------------------------------
module tx_word_fifo #(
	parameter int WIDTH = `WORD_W,
	parameter int DEPTH = `TX_FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0] wr_ptr_ff;
	logic [AW-1:0] rd_ptr_ff;
	logic [AW:0] count_ff;
	logic push;
	logic pop;

	assign in_ready = (count_ff != DEPTH[AW:0]);
	assign out_valid = (count_ff != '0);
	assign out_data = mem_ff[rd_ptr_ff];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always_ff @(posedge clk) begin
		if (push) begin
			mem_ff[wr_ptr_ff] <= in_data;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff <= '0;
		end else begin
			if (push) begin
				wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
			end
			if (pop) begin
				rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
			end
			count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// ---------------------------------------------------------------
// pin mux top
// ---------------------------------------------------------------
module transceiver_pin_function_mux
	import pin_mux_pkg::*;
#(
	parameter bit FULL_VARIANT = 1'b1,
	parameter int SYNC_LOSS_CYCLES = `SYNC_LOSS_CYCLES,
	parameter int WORD_W = `WORD_W,
	parameter int FIFO_DEPTH = `TX_FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic link_clk,
	// configuration
	input wire logic main_role,
	input wire logic tx0_en,
	input wire logic tx1_en,
	input wire logic rx1_alt_en,
	input wire logic rx0_en,
	input wire logic mic0_en,
	input wire logic mic_clk_on_bclk,
	input wire logic clkout_b_en,
	input wire logic [`GPIO_COUNT-1:0] gpio_en,
	input wire logic [`GPIO_COUNT-1:0] gpio_drive,
	input wire logic [`GPIO_COUNT-1:0] gpio_out,
	// status
	output logic [`GPIO_COUNT-1:0] gpio_in,
	output logic mic_input0,
	output logic [1:0] i2c_addr,
	output logic addr_valid,
	output logic bus_reset,
	output logic sync_lost,
	// transmit words
	input wire logic [WORD_W-1:0] tx_data,
	input wire logic tx_valid,
	output logic tx_ready,
	// receive words
	output logic [WORD_W-1:0] rx_data,
	output logic rx_valid,
	// pins
	input wire logic addr_strap_a_i,
	input wire logic addr_strap_b_pin_i,
	output logic addr_strap_b_pin_o,
	output logic addr_strap_b_pin_oe_n,
	input wire logic bit_clk_i,
	output logic bit_clk_o,
	output logic bit_clk_oe_n,
	input wire logic frame_sync_i,
	output logic frame_sync_o,
	output logic frame_sync_oe_n,
	input wire logic tx_lane0_pin_i,
	output logic tx_lane0_pin_o,
	output logic tx_lane0_pin_oe_n,
	input wire logic tx_lane1_pin_i,
	output logic tx_lane1_pin_o,
	output logic tx_lane1_pin_oe_n,
	input wire logic rx_lane0_pin_i,
	output logic rx_lane0_pin_o,
	output logic rx_lane0_pin_oe_n
);
	localparam int LW = $clog2(SYNC_LOSS_CYCLES + 1);
	localparam int FW = $clog2(`FRAME_BITS);
	localparam int NP = `PIN_COUNT;
	localparam int NG = `GPIO_COUNT;

	// ---------------------------------------------------------------
	// input synchronisers: three flops, change taken when 2nd and 3rd agree; address straps two flops, no agreement
	// ---------------------------------------------------------------
	logic [NG-1:0] gp_raw;
	logic [NG-1:0] gp_s1_ff, gp_s2_ff, gp_s3_ff;
	logic [NG-1:0] gp_val_ff;
	logic [2:0] fs_sync_ff;
	logic [1:0] strap_a_ff, strap_b_ff;
	logic fs_val_ff;
	logic rx0_s1_ff, rx0_s2_ff, rx0_s3_ff;

	assign gp_raw = {rx_lane0_pin_i, tx_lane1_pin_i, tx_lane0_pin_i, addr_strap_b_pin_i};

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			gp_s1_ff <= '0;
			gp_s2_ff <= '0;
			gp_s3_ff <= '0;
			fs_sync_ff <= 3'h0;
			rx0_s1_ff <= 1'b0;
			rx0_s2_ff <= 1'b0;
			rx0_s3_ff <= 1'b0;
			strap_a_ff <= 2'h0;
			strap_b_ff <= 2'h0;
		end else begin
			gp_s1_ff <= gp_raw;
			gp_s2_ff <= gp_s1_ff;
			gp_s3_ff <= gp_s2_ff;
			fs_sync_ff <= {fs_sync_ff[1:0], frame_sync_i};
			rx0_s1_ff <= rx_lane0_pin_i;
			rx0_s2_ff <= rx0_s1_ff;
			rx0_s3_ff <= rx0_s2_ff;
			strap_a_ff <= {strap_a_ff[0], addr_strap_a_i};
			strap_b_ff <= {strap_b_ff[0], addr_strap_b_pin_i};
		end
	end

	// ---------------------------------------------------------------
	// address strap capture after reset release
	// ---------------------------------------------------------------
	logic [2:0] strap_cnt_ff;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			strap_cnt_ff <= 3'h0;
			addr_valid <= 1'b0;
			i2c_addr <= 2'h0;
		end else if (!addr_valid) begin
			strap_cnt_ff <= strap_cnt_ff + 3'h1;
			if (strap_cnt_ff == 3'(`STRAP_SETTLE_CYCLES - 1)) begin
				i2c_addr <= {strap_b_ff[1], strap_a_ff[1]};
				addr_valid <= 1'b1;
			end
		end
	end

	// ---------------------------------------------------------------
	// frame sync watchdog, main role only
	// ---------------------------------------------------------------
	logic [LW-1:0] loss_cnt_ff;
	logic loss_reset_ff;
	logic fs_edge;

	assign fs_edge = (fs_sync_ff[1] == fs_sync_ff[2]) && (fs_sync_ff[2] != fs_val_ff);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fs_val_ff <= 1'b0;
			loss_cnt_ff <= '0;
			loss_reset_ff <= 1'b0;
			sync_lost <= 1'b0;
			bus_reset <= 1'b0;
		end else begin
			sync_lost <= 1'b0;
			if (fs_sync_ff[1] == fs_sync_ff[2]) begin
				fs_val_ff <= fs_sync_ff[2];
			end
			if (!main_role || fs_edge) begin
				loss_cnt_ff <= '0;
				loss_reset_ff <= 1'b0;
			end else if (loss_cnt_ff == LW'(SYNC_LOSS_CYCLES - 1)) begin
				loss_reset_ff <= 1'b1;
				sync_lost <= !loss_reset_ff;
			end else begin
				loss_cnt_ff <= loss_cnt_ff + 1'b1;
			end
			bus_reset <= loss_reset_ff;
		end
	end

	// ---------------------------------------------------------------
	// clock dividers
	// ---------------------------------------------------------------
	logic [3:0] aux_cnt_ff, mic_cnt_ff, bclk_cnt_ff;
	logic aux_clk_ff, mic_clk_ff, bclk_gen_ff;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			aux_cnt_ff <= 4'h0;
			mic_cnt_ff <= 4'h0;
			bclk_cnt_ff <= 4'h0;
			aux_clk_ff <= 1'b0;
			mic_clk_ff <= 1'b0;
			bclk_gen_ff <= 1'b0;
		end else begin
			aux_cnt_ff <= (aux_cnt_ff == 4'(`AUX_CLK_HALF - 1)) ? 4'h0 : aux_cnt_ff + 4'h1;
			mic_cnt_ff <= (mic_cnt_ff == 4'(`MIC_CLK_HALF - 1)) ? 4'h0 : mic_cnt_ff + 4'h1;
			bclk_cnt_ff <= (bclk_cnt_ff == 4'(`BIT_CLK_HALF - 1)) ? 4'h0 : bclk_cnt_ff + 4'h1;
			if (aux_cnt_ff == 4'(`AUX_CLK_HALF - 1)) begin
				aux_clk_ff <= !aux_clk_ff;
			end
			if (mic_cnt_ff == 4'(`MIC_CLK_HALF - 1)) begin
				mic_clk_ff <= !mic_clk_ff;
			end
			if (bclk_cnt_ff == 4'(`BIT_CLK_HALF - 1)) begin
				bclk_gen_ff <= !bclk_gen_ff;
			end
		end
	end

	// ---------------------------------------------------------------
	// function selection per pin
	// ---------------------------------------------------------------
	pin_fn_t fn_strap_b, fn_tx0, fn_tx1, fn_rx0;
	logic tx1_rx_alt;
	logic mic_on_bclk;
	logic [NP-1:0] nxt_drive;
	logic [NP-1:0] nxt_ien;
	logic [NP-1:0] drive_ff;
	logic [NP-1:0] ien_ff;

	always_comb begin
		tx1_rx_alt = 1'b0;
		mic_on_bclk = !main_role && mic0_en && mic_clk_on_bclk;
		fn_strap_b = fn_hiz;
		if (clkout_b_en) begin
			fn_strap_b = fn_clk;
		end else if (gpio_en[`GPIO_STRAP_B]) begin
			fn_strap_b = fn_gpio;
		end
		fn_tx0 = fn_hiz;
		if (FULL_VARIANT && tx0_en) begin
			fn_tx0 = fn_serial;
		end else if (gpio_en[`GPIO_THREE]) begin
			fn_tx0 = fn_gpio;
		end
		fn_tx1 = fn_hiz;
		if (FULL_VARIANT && tx1_en) begin
			fn_tx1 = fn_serial;
		end else if (FULL_VARIANT && rx1_alt_en && mic0_en) begin
			fn_tx1 = fn_serial;
			tx1_rx_alt = 1'b1;
		end else if (gpio_en[`GPIO_FOUR]) begin
			fn_tx1 = fn_gpio;
		end
		fn_rx0 = fn_hiz;
		if (FULL_VARIANT && rx0_en) begin
			fn_rx0 = fn_serial;
		end else if (mic0_en) begin
			fn_rx0 = fn_mic;
		end else if (gpio_en[`GPIO_FIVE]) begin
			fn_rx0 = fn_gpio;
		end
		nxt_drive = '0;
		nxt_ien = '0;
		nxt_drive[`PIN_STRAP_B] = (fn_strap_b == fn_clk) ||
			((fn_strap_b == fn_gpio) && gpio_drive[`GPIO_STRAP_B]);
		nxt_ien[`PIN_STRAP_B] = (fn_strap_b == fn_gpio);
		nxt_drive[`PIN_BCLK] = !main_role;
		nxt_ien[`PIN_BCLK] = main_role;
		nxt_drive[`PIN_FSYNC] = !main_role;
		nxt_ien[`PIN_FSYNC] = main_role;
		nxt_drive[`PIN_TX0] = (fn_tx0 == fn_serial) ||
			((fn_tx0 == fn_gpio) && gpio_drive[`GPIO_THREE]);
		nxt_ien[`PIN_TX0] = (fn_tx0 == fn_gpio);
		nxt_drive[`PIN_TX1] = ((fn_tx1 == fn_serial) && !tx1_rx_alt) ||
			((fn_tx1 == fn_gpio) && gpio_drive[`GPIO_FOUR]);
		nxt_ien[`PIN_TX1] = tx1_rx_alt || (fn_tx1 == fn_gpio);
		nxt_drive[`PIN_RX0] = (fn_rx0 == fn_gpio) && gpio_drive[`GPIO_FIVE];
		nxt_ien[`PIN_RX0] = (fn_rx0 != fn_hiz);
		if (loss_reset_ff) begin
			nxt_drive = '0;
			nxt_ien = '0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			drive_ff <= '0;
			ien_ff <= '0;
			addr_strap_b_pin_o <= 1'b0;
			bit_clk_o <= 1'b0;
			gp_val_ff <= '0;
			mic_input0 <= 1'b0;
		end else begin
			drive_ff <= nxt_drive;
			ien_ff <= nxt_ien;
			addr_strap_b_pin_o <= (fn_strap_b == fn_clk) ? aux_clk_ff : gpio_out[`GPIO_STRAP_B];
			bit_clk_o <= mic_on_bclk ? mic_clk_ff : bclk_gen_ff;
			mic_input0 <= (fn_rx0 == fn_mic) && ien_ff[`PIN_RX0] &&
				(rx0_s2_ff == rx0_s3_ff) ? rx0_s3_ff : mic_input0;
			for (int g = 0; g < NG; g++) begin
				if (gp_s2_ff[g] == gp_s3_ff[g]) begin
					gp_val_ff[g] <= gp_s3_ff[g];
				end
			end
		end
	end

	assign gpio_in = gp_val_ff & {ien_ff[`PIN_RX0], ien_ff[`PIN_TX1], ien_ff[`PIN_TX0],
		ien_ff[`PIN_STRAP_B]};
	assign addr_strap_b_pin_oe_n = !drive_ff[`PIN_STRAP_B];
	assign bit_clk_oe_n = !drive_ff[`PIN_BCLK];
	assign frame_sync_oe_n = !drive_ff[`PIN_FSYNC];
	assign tx_lane0_pin_oe_n = !drive_ff[`PIN_TX0];
	assign tx_lane1_pin_oe_n = !drive_ff[`PIN_TX1];
	assign rx_lane0_pin_oe_n = !drive_ff[`PIN_RX0];
	assign rx_lane0_pin_o = gpio_out[`GPIO_FIVE];

	// ---------------------------------------------------------------
	// transmit buffer and word handshake toward link domain
	// ---------------------------------------------------------------
	logic [WORD_W-1:0] fifo_data;
	logic fifo_valid;
	logic fifo_pop;
	logic [WORD_W-1:0] hs_word_ff;
	logic hs_req_ff;
	logic [1:0] hs_ack_sync_ff;
	logic lk_ack_ff;
	hs_state_t hs_state_ff;

	tx_word_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
		.clk(clk),
		.rst(rst),
		.in_data(tx_data),
		.in_valid(tx_valid),
		.in_ready(tx_ready),
		.out_data(fifo_data),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop)
	);

	assign fifo_pop = (hs_state_ff == hs_idle);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hs_state_ff <= hs_idle;
			hs_req_ff <= 1'b0;
			hs_word_ff <= '0;
			hs_ack_sync_ff <= 2'h0;
		end else begin
			hs_ack_sync_ff <= {hs_ack_sync_ff[0], lk_ack_ff};
			case (hs_state_ff)
				hs_idle: begin
					if (fifo_valid) begin
						hs_word_ff <= fifo_data;
						hs_req_ff <= !hs_req_ff;
						hs_state_ff <= hs_busy;
					end
				end
				default: begin
					if (hs_ack_sync_ff[1] == hs_req_ff) begin
						hs_state_ff <= hs_idle;
					end
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// link domain: framing, serialiser, deserialiser
	// ---------------------------------------------------------------
	logic [1:0] lk_rst_ff;
	logic lk_rst;
	logic [1:0] lk_req_sync_ff;
	logic lk_fs_prev_ff;
	logic [FW-1:0] lk_bit_ff;
	logic lk_frame_start;
	logic [WORD_W-1:0] lk_tx_sh_ff;
	logic [WORD_W-1:0] lk_rx_sh_ff;
	logic [WORD_W-1:0] lk_rx_hold_ff;
	logic lk_rx_tgl_ff;
	logic lk_rx_bit;

	assign lk_rst = lk_rst_ff[1];
	assign lk_frame_start = main_role ? (frame_sync_i && !lk_fs_prev_ff) : (lk_bit_ff == '0);
	assign lk_rx_bit = tx1_rx_alt ? tx_lane1_pin_i : rx_lane0_pin_i;

	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			lk_rst_ff <= 2'h3;
		end else begin
			lk_rst_ff <= {lk_rst_ff[0], 1'b0};
		end
	end

	always_ff @(posedge link_clk or posedge lk_rst) begin
		if (lk_rst) begin
			lk_req_sync_ff <= 2'h0;
			lk_ack_ff <= 1'b0;
			lk_fs_prev_ff <= 1'b0;
			lk_bit_ff <= '0;
			lk_tx_sh_ff <= '0;
			frame_sync_o <= 1'b0;
		end else begin
			lk_req_sync_ff <= {lk_req_sync_ff[0], hs_req_ff};
			lk_fs_prev_ff <= frame_sync_i;
			lk_bit_ff <= lk_frame_start ? FW'(1) : lk_bit_ff + 1'b1;
			frame_sync_o <= lk_frame_start;
			if (lk_frame_start) begin
				lk_tx_sh_ff <= '0;
				if (lk_req_sync_ff[1] != lk_ack_ff) begin
					lk_tx_sh_ff <= hs_word_ff;
					lk_ack_ff <= lk_req_sync_ff[1];
				end
			end else begin
				lk_tx_sh_ff <= {lk_tx_sh_ff[WORD_W-2:0], 1'b0};
			end
		end
	end

	always_ff @(posedge link_clk or posedge lk_rst) begin
		if (lk_rst) begin
			tx_lane0_pin_o <= 1'b0;
			tx_lane1_pin_o <= 1'b0;
			lk_rx_sh_ff <= '0;
			lk_rx_hold_ff <= '0;
			lk_rx_tgl_ff <= 1'b0;
		end else begin
			tx_lane0_pin_o <= (fn_tx0 == fn_serial) ? lk_tx_sh_ff[WORD_W-1] :
				gpio_out[`GPIO_THREE];
			tx_lane1_pin_o <= (fn_tx1 == fn_serial) ? lk_tx_sh_ff[WORD_W-1] :
				gpio_out[`GPIO_FOUR];
			lk_rx_sh_ff <= {lk_rx_sh_ff[WORD_W-2:0], lk_rx_bit};
			if (lk_frame_start && ((fn_rx0 == fn_serial) || tx1_rx_alt)) begin
				lk_rx_hold_ff <= lk_rx_sh_ff;
				lk_rx_tgl_ff <= !lk_rx_tgl_ff;
			end
		end
	end

	// ---------------------------------------------------------------
	// received word into clk domain
	// ---------------------------------------------------------------
	logic [2:0] rx_tgl_sync_ff;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rx_tgl_sync_ff <= 3'h0;
			rx_data <= '0;
			rx_valid <= 1'b0;
		end else begin
			rx_tgl_sync_ff <= {rx_tgl_sync_ff[1:0], lk_rx_tgl_ff};
			rx_valid <= rx_tgl_sync_ff[2] != rx_tgl_sync_ff[1];
			if (rx_tgl_sync_ff[2] != rx_tgl_sync_ff[1]) begin
				rx_data <= lk_rx_hold_ff;
			end
		end
	end
endmodule

/* dv/host_tdm_model.sv */
// Purpose: host side of the serial port, frame sync and receive lane
// Assumes: frames of 32 link clocks, word sent msb first
// Notes: stopped host holds sync still and toggles its data line
`timescale 1ns/100ps
module host_tdm_model (
	input wire logic link_clk,
	input wire logic run,
	input wire logic [31:0] word,
	output logic bit_clk,
	output logic frame_sync,
	output logic sdata
);
	logic [4:0] cnt_ff;
	initial begin
		cnt_ff = 5'h1f;
		frame_sync = 1'b0;
		sdata = 1'b0;
	end
	assign bit_clk = run & link_clk;
	always @(posedge link_clk) begin
		if (run) begin
			cnt_ff <= cnt_ff + 5'h01;
			// wide sync so the filtered input always sees both edges
			frame_sync <= (cnt_ff == 5'h1f) || !cnt_ff[4];
			sdata <= word[~cnt_ff];
		end else begin
			// restart with a frame at once
			cnt_ff <= 5'h1f;
			sdata <= ~sdata;
		end
	end
endmodule

/* dv/pin_mux_sva.sv */
// Purpose: port assertions for the pin function mux
// Assumes: bound to the top module from the bench
// Notes: oe_n low means the device drives the pin
`timescale 1ns/100ps
`include "pin_mux_params.svh"
module pin_mux_sva #(
	parameter bit FULL_VARIANT = 1'b1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic main_role,
	input wire logic tx0_en,
	input wire logic rx0_en,
	input wire logic clkout_b_en,
	input wire logic [`GPIO_COUNT-1:0] gpio_en,
	input wire logic [`GPIO_COUNT-1:0] gpio_in,
	input wire logic [1:0] i2c_addr,
	input wire logic addr_valid,
	input wire logic bus_reset,
	input wire logic sync_lost,
	input wire logic rx_valid,
	input wire logic addr_strap_b_pin_oe_n,
	input wire logic bit_clk_oe_n,
	input wire logic frame_sync_oe_n,
	input wire logic tx_lane0_pin_oe_n,
	input wire logic tx_lane1_pin_oe_n,
	input wire logic rx_lane0_pin_oe_n
);
	wire logic all_hiz = addr_strap_b_pin_oe_n & bit_clk_oe_n & frame_sync_oe_n
		& tx_lane0_pin_oe_n & tx_lane1_pin_oe_n & rx_lane0_pin_oe_n;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// ----------
	// role held for two cycles
	// ----------
	sequence s_main_held;
		main_role [*2];
	endsequence
	sequence s_sub_held;
		(!main_role && !bus_reset) [*2];
	endsequence
	a_reset_hiz: assert property (disable iff (1'b0) rst |-> all_hiz && gpio_in == '0)
		else $error("pin driven or input live in reset");
	a_main_inputs: assert property (s_main_held |-> bit_clk_oe_n && frame_sync_oe_n)
		else $error("main node drives clock or sync");
	a_sub_drives: assert property (s_sub_held |-> !bit_clk_oe_n && !frame_sync_oe_n)
		else $error("subordinate node leaves clock or sync undriven");
	a_strap_idle: assert property ((!gpio_en[`GPIO_STRAP_B] && !clkout_b_en) [*2]
		|-> addr_strap_b_pin_oe_n) else $error("strap pin driven while unconfigured");
	a_lane0_idle: assert property ((!tx0_en && !gpio_en[`GPIO_THREE]) [*2]
		|-> tx_lane0_pin_oe_n) else $error("lane zero driven while unconfigured");
	a_lane0_serial: assert property ((FULL_VARIANT && tx0_en && !bus_reset) [*2]
		|-> !tx_lane0_pin_oe_n) else $error("lane zero not driven with transmit on");
	a_rx0_input: assert property ((FULL_VARIANT && rx0_en) [*2] |-> rx_lane0_pin_oe_n)
		else $error("receive pin driven with receive on");
	a_lost_hiz: assert property (bus_reset [*2] |-> all_hiz)
		else $error("pin driven after sync loss");
	a_lost_flag: assert property (sync_lost |-> ##[0:1] bus_reset ##1 !sync_lost)
		else $error("sync loss pulse without bus reset");
	a_addr_hold: assert property (addr_valid |=> addr_valid && $stable(i2c_addr))
		else $error("captured address changed");
	a_rx_pulse: assert property (rx_valid |=> !rx_valid)
		else $error("receive strobe longer than one cycle");
endmodule

/* dv/transceiver_pin_function_mux_tb.sv */
// Purpose: self-checking bench for the pin function mux
// Assumes: host model on the serial port, shortened sync watchdog
// Notes: pin levels resolved from oe_n, o and outside drive
`timescale 1ns/100ps
`include "pin_mux_params.svh"
module transceiver_pin_function_mux_tb;
	logic clk, rst, link_clk, main_role, tx0_en, tx1_en, rx0_en, mic0_en, mic_clk_on_bclk;
	logic clkout_b_en, host_run, use_host, tx_valid, tx_ready, rx_valid, mic_input0;
	logic addr_valid, bus_reset, sync_lost, host_bclk, host_fs, host_sd;
	logic [3:0] gpio_en, gpio_drive, gpio_out, ext, gpio_in;
	logic [31:0] tx_data, rx_data, host_word;
	logic [1:0] i2c_addr;
	logic bit_clk_o, bit_clk_oe_n, frame_sync_o, frame_sync_oe_n;
	logic addr_strap_b_pin_o, addr_strap_b_pin_oe_n, rx_lane0_pin_o, rx_lane0_pin_oe_n;
	logic tx_lane0_pin_o, tx_lane0_pin_oe_n, tx_lane1_pin_o, tx_lane1_pin_oe_n;
	int n_errors = 0;
	int n_compared = 0;
	wire logic bclk_pin = bit_clk_oe_n ? host_bclk : bit_clk_o;
	wire logic fs_pin = frame_sync_oe_n ? host_fs : frame_sync_o;
	wire logic strap_pin = addr_strap_b_pin_oe_n ? ext[0] : addr_strap_b_pin_o;
	wire logic tx0_pin = tx_lane0_pin_oe_n ? ext[1] : tx_lane0_pin_o;
	wire logic tx1_pin = tx_lane1_pin_oe_n ? ext[2] : tx_lane1_pin_o;
	wire logic rx0_pin = rx_lane0_pin_oe_n ? (use_host ? host_sd : ext[3]) : rx_lane0_pin_o;
	wire logic [5:0] oe_all = {addr_strap_b_pin_oe_n, bit_clk_oe_n, frame_sync_oe_n,
		tx_lane0_pin_oe_n, tx_lane1_pin_oe_n, rx_lane0_pin_oe_n};
	wire logic [2:0] lane_oe_n = {rx_lane0_pin_oe_n, tx_lane1_pin_oe_n, tx_lane0_pin_oe_n};
	wire logic [2:0] lane_o = {rx_lane0_pin_o, tx_lane1_pin_o, tx_lane0_pin_o};
	// ----------
	// design and host
	// ----------
	transceiver_pin_function_mux #(.SYNC_LOSS_CYCLES(50)) dut_u (.clk, .rst, .link_clk,
		.main_role, .tx0_en, .tx1_en, .rx1_alt_en(1'b0), .rx0_en, .mic0_en, .mic_clk_on_bclk,
		.clkout_b_en, .gpio_en, .gpio_drive, .gpio_out, .gpio_in, .mic_input0, .i2c_addr,
		.addr_valid, .bus_reset, .sync_lost, .tx_data, .tx_valid, .tx_ready, .rx_data,
		.rx_valid, .addr_strap_a_i(1'b1), .addr_strap_b_pin_i(strap_pin), .addr_strap_b_pin_o,
		.addr_strap_b_pin_oe_n, .bit_clk_i(bclk_pin), .bit_clk_o, .bit_clk_oe_n,
		.frame_sync_i(fs_pin), .frame_sync_o, .frame_sync_oe_n, .tx_lane0_pin_i(tx0_pin),
		.tx_lane0_pin_o, .tx_lane0_pin_oe_n, .tx_lane1_pin_i(tx1_pin), .tx_lane1_pin_o,
		.tx_lane1_pin_oe_n, .rx_lane0_pin_i(rx0_pin), .rx_lane0_pin_o, .rx_lane0_pin_oe_n);
	host_tdm_model host_u (.link_clk, .run(host_run), .word(host_word), .bit_clk(host_bclk),
		.frame_sync(host_fs), .sdata(host_sd));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		link_clk = 1'b0;
		#3.3;
		forever #7.5 link_clk = ~link_clk;
	end
	// ----------
	// helpers
	// ----------
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	function automatic logic has_word(input logic [127:0] c, input logic [31:0] w);
		has_word = 1'b0;
		for (int k = 0; k <= 96; k++) if (c[k+:32] === w) has_word = 1'b1;
	endfunction
	task automatic wait_rx();
		for (int i = 0; i < 200 && rx_valid !== 1'b1; i++) tick(1);
		chk(rx_valid, 1);
		tick(1);
	endtask
	task automatic finish_test();
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// ----------
	// scenarios
	// ----------
	task automatic t_addr();
		tick(3);
		chk(addr_valid, 0);
		tick(1);
		chk({addr_valid, i2c_addr}, 5);
	endtask
	task automatic t_direction();
		int f0, f1;
		tick(3);
		chk({bit_clk_oe_n, frame_sync_oe_n}, 3);
		main_role = 1'b0;
		tick(3);
		chk({bit_clk_oe_n, frame_sync_oe_n}, 0);
		{mic0_en, mic_clk_on_bclk} = 2'h3;
		tick(3);
		chk(bit_clk_oe_n, 0);
		f0 = -1;
		f1 = -1;
		for (int i = 0; i < 100; i++) begin
			@(posedge link_clk);
			if (frame_sync_o === 1'b1 && f0 < 0) f0 = i;
			else if (frame_sync_o === 1'b1 && f1 < 0) f1 = i;
		end
		chk(f1 - f0, 32);
		tick(1);
		{main_role, mic0_en, mic_clk_on_bclk} = 3'h4;
		tick(3);
	endtask
	task automatic t_gpio();
		for (int i = 1; i < 4; i++) begin
			{gpio_en[i], gpio_drive[i], gpio_out[i]} = 3'h7;
			tick(3);
			chk({lane_oe_n[i-1], lane_o[i-1]}, 1);
			{gpio_drive[i], ext[i]} = 2'h1;
			tick(6);
			chk({lane_oe_n[i-1], gpio_in[i]}, 3);
			gpio_en[i] = 1'b0;
			tick(3);
			chk({lane_oe_n[i-1], gpio_in[i]}, 2);
			ext[i] = 1'b0;
		end
	endtask
	task automatic t_strap_b();
		int t;
		logic last;
		{gpio_en[0], gpio_drive[0], gpio_out[0]} = 3'h7;
		tick(3);
		chk({addr_strap_b_pin_oe_n, addr_strap_b_pin_o}, 1);
		clkout_b_en = 1'b1;
		tick(3);
		t = 0;
		last = addr_strap_b_pin_o;
		for (int i = 0; i < 40; i++) begin
			tick(1);
			t += (addr_strap_b_pin_o !== last);
			last = addr_strap_b_pin_o;
		end
		chk({addr_strap_b_pin_oe_n, t >= 9 && t <= 10}, 1);
		{clkout_b_en, gpio_en[0]} = 2'h0;
		tick(3);
		chk(addr_strap_b_pin_oe_n, 1);
	endtask
	task automatic t_rx();
		{use_host, rx0_en} = 2'h3;
		wait_rx();
		wait_rx();
		chk(has_word({64'h0, {2{host_word}}}, rx_data), 1);
		mic0_en = 1'b1;
		wait_rx();
		chk(has_word({64'h0, {2{host_word}}}, rx_data), 1);
		{rx0_en, use_host, ext[3]} = 3'h1;
		tick(8);
		chk(mic_input0, 1);
		ext[3] = 1'b0;
		tick(8);
		chk({mic_input0, rx_lane0_pin_oe_n}, 1);
		mic0_en = 1'b0;
	endtask
	task automatic t_tx_fifo();
		int n;
		logic [127:0] cap;
		n = 0;
		{tx0_en, tx1_en, gpio_en, gpio_drive} = 10'h322;
		@(negedge host_fs);
		tick(1);
		host_run = 1'b0;
		tx_valid = 1'b1;
		for (int i = 0; i < 40; i++) begin
			tx_data = {16'ha5c3, i[15:0]};
			if (tx_ready !== 1'b1) break;
			n++;
			tick(1);
		end
		tx_valid = 1'b0;
		chk(n, 17);
		host_run = 1'b1;
		for (int i = 0; i < 128; i++) begin
			@(posedge link_clk);
			cap = {cap[126:0], tx_lane0_pin_o};
		end
		chk(has_word(cap, 32'ha5c3_0000), 1);
		chk(tx_lane1_pin_oe_n, 0);
		for (int i = 0; i < 3000 && tx_ready !== 1'b1; i++) tick(1);
		chk(tx_ready, 1);
		{tx0_en, tx1_en, gpio_en, gpio_drive} = 10'h000;
	endtask
	task automatic t_sync_loss();
		int i;
		{gpio_en, gpio_drive} = 8'h22;
		tick(3);
		chk(tx_lane0_pin_oe_n, 0);
		host_run = 1'b0;
		for (i = 0; i < 300 && bus_reset !== 1'b1; i++) tick(1);
		chk((i > 3) && (i < 120), 1);
		tick(1);
		chk(oe_all, 32'h0000_003f);
		host_run = 1'b1;
		for (i = 0; i < 300 && bus_reset !== 1'b0; i++) tick(1);
		tick(3);
		chk({bus_reset, tx_lane0_pin_oe_n}, 0);
		{gpio_en, gpio_drive} = 8'h00;
	endtask
	// ----------
	// main sequence and watchdog
	// ----------
	initial begin
		rst = 1'b1;
		{tx1_en, rx0_en, mic0_en, mic_clk_on_bclk, clkout_b_en, tx_valid, use_host} = '0;
		{main_role, tx0_en, host_run} = 3'h3;
		{gpio_en, gpio_drive, gpio_out, ext} = 16'hee00;
		tx_data = 32'h0000_0000;
		host_word = 32'h96c3_5a0f;
		tick(5);
		chk({oe_all, gpio_in, addr_valid, tx_ready}, 32'h0000_0fc1);
		{main_role, tx0_en, gpio_en, gpio_drive} = 10'h200;
		tick(5);
		rst = 1'b0;
		t_addr();
		t_direction();
		t_gpio();
		t_strap_b();
		t_rx();
		t_tx_fifo();
		t_sync_loss();
		finish_test();
	end
	initial begin
		#300000;
		n_errors++;
		finish_test();
	end
endmodule

bind transceiver_pin_function_mux pin_mux_sva #(.FULL_VARIANT(FULL_VARIANT)) sva_u (.clk,
	.rst, .main_role, .tx0_en, .rx0_en, .clkout_b_en, .gpio_en, .gpio_in, .i2c_addr,
	.addr_valid, .bus_reset, .sync_lost, .rx_valid, .addr_strap_b_pin_oe_n, .bit_clk_oe_n,
	.frame_sync_oe_n, .tx_lane0_pin_oe_n, .tx_lane1_pin_oe_n, .rx_lane0_pin_oe_n);
